// [hw/pwmsd_top.v]
// PWM block with prescaled and scaled clocks, eight channels and emergency shutdown
`timescale 1ns/1ps
`include "pwmsd_regs.vh"
module pwmsd_top (
  input wire clock,
  input wire rst_n,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire freeze_mode,
  input wire ch7_pin_in,
  output reg [7:0] pwm_out,
  output reg [7:0] pwm_oe,
  output reg shutdown_irq
);
  localparam NCH = 8;

  // Register state
  reg [7:0] channel_run_enable_reg;
  reg [7:0] pol_reg;
  reg [7:0] clock_choice_reg;
  reg [7:0] prescale_select_reg;
  reg [7:0] module_control_reg;
  reg [7:0] scale_value_a_reg;
  reg [7:0] scale_value_b_reg;
  reg shutdown_change_flag_reg;
  reg shutdown_irq_enable_reg;
  reg shutdown_output_level_reg;
  reg shutdown_active_polarity_reg;
  reg shutdown_feature_enable_reg;
  reg ack_reg;

  // Clock generation state
  reg [6:0] pre_cnt_reg;
  reg [7:0] sa_cnt_reg;
  reg [7:0] sb_cnt_reg;
  reg sa_tgl_reg;
  reg sb_tgl_reg;

  // Shutdown state
  reg pin_s1_reg;
  reg pin_s2_reg;
  reg pin_s3_reg;
  reg restart_pend_reg;
  reg [7:0] hold_reg;

  wire [5:0] idx;
  wire wr_en;
  wire [7:0] wb;
  wire pre_run;
  wire tick_a;
  wire tick_b;
  wire pulse_a;
  wire pulse_b;
  wire tick_sa;
  wire tick_sb;
  wire sd_active;
  wire pin_change;
  wire [7:0] ch_tick;
  wire [7:0] ch_wave;
  wire [7:0] ch_zero;
  wire [63:0] ch_per;
  wire [63:0] ch_dty;
  wire [63:0] ch_cnt;
  wire sdn_wr;
  wire scale_a_wr;
  wire scale_b_wr;
  reg [7:0] rd_byte;
  reg rd_hit;
  reg [7:0] hold_next;
  reg [7:0] out_next;
  integer k;

  // Mask of low prescaler bits that must be all ones for a tick
  function [6:0] pwmsd_div_mask;
    input [2:0] sel;
    begin
      pwmsd_div_mask = 7'h7F >> (3'h7 - sel);
      if (sel == 3'h0)
        pwmsd_div_mask = 7'h00;
    end
  endfunction

  assign idx = paddr[7:2];
  assign wb = pwdata[7:0];
  assign pready = ack_reg & clk_en;
  assign wr_en = psel & penable & pwrite & ack_reg;

  // Write strobes used by the scale counter and shutdown processes
  assign sdn_wr = wr_en & (idx == `PWMSD_IDX_SDN);
  assign scale_a_wr = wr_en & (idx == `PWMSD_IDX_SCALE_A);
  assign scale_b_wr = wr_en & (idx == `PWMSD_IDX_SCALE_B);

  // Prescaler runs only when not frozen and some channel is enabled
  assign pre_run = ~(module_control_reg[`PWMSD_CTRL_FRZ] & freeze_mode)
                   & (|channel_run_enable_reg);
  assign tick_a = pre_run & ((pre_cnt_reg & pwmsd_div_mask(prescale_select_reg[`PWMSD_PRE_A_LSB +: 3]))
                  == pwmsd_div_mask(prescale_select_reg[`PWMSD_PRE_A_LSB +: 3]));
  assign tick_b = pre_run & ((pre_cnt_reg & pwmsd_div_mask(prescale_select_reg[`PWMSD_PRE_B_LSB +: 3]))
                  == pwmsd_div_mask(prescale_select_reg[`PWMSD_PRE_B_LSB +: 3]));

  // Down counter pulses on reaching one; a loaded zero takes 256 ticks
  assign pulse_a = tick_a & (sa_cnt_reg == 8'h01);
  assign pulse_b = tick_b & (sb_cnt_reg == 8'h01);
  assign tick_sa = pulse_a & sa_tgl_reg;
  assign tick_sb = pulse_b & sb_tgl_reg;

  // Shutdown input decode on the synchronised pin value
  assign sd_active = shutdown_feature_enable_reg
                     & (pin_s2_reg == shutdown_active_polarity_reg);
  assign pin_change = shutdown_feature_enable_reg & (pin_s2_reg ^ pin_s3_reg);

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : gen_ch
      // Channels with index bit 1 clear use A/SA, the others B/SB
      if (g % 4 < 2)
      begin : grp_a
        assign ch_tick[g] = clock_choice_reg[g] ? tick_sa : tick_a;
      end
      else
      begin : grp_b
        assign ch_tick[g] = clock_choice_reg[g] ? tick_sb : tick_b;
      end
      pwmsd_chan pwmsd_chan_i (
        .clock(clock),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .tick(ch_tick[g]),
        .run(channel_run_enable_reg[g]),
        .pol(pol_reg[g]),
        .per_wr(wr_en && idx == `PWMSD_IDX_PER0 + g),
        .dty_wr(wr_en && idx == `PWMSD_IDX_DTY0 + g),
        .cnt_wr(wr_en && idx == `PWMSD_IDX_CNT0 + g),
        .wdata(wb),
        .per_buf_reg(ch_per[8*g +: 8]),
        .dty_buf_reg(ch_dty[8*g +: 8]),
        .cnt_reg(ch_cnt[8*g +: 8]),
        .wave(ch_wave[g]),
        .cnt_zero(ch_zero[g])
      );
    end
  endgenerate

  // Read decode
  always @*
  begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    if (idx == `PWMSD_IDX_ENABLE)
      rd_byte = channel_run_enable_reg;
    else if (idx == `PWMSD_IDX_POL)
      rd_byte = pol_reg;
    else if (idx == `PWMSD_IDX_CLKSEL)
      rd_byte = clock_choice_reg;
    else if (idx == `PWMSD_IDX_PRESCALE)
      rd_byte = prescale_select_reg;
    else if (idx == `PWMSD_IDX_CTRL)
      rd_byte = module_control_reg;
    else if (idx == `PWMSD_IDX_SCALE_A)
      rd_byte = scale_value_a_reg;
    else if (idx == `PWMSD_IDX_SCALE_B)
      rd_byte = scale_value_b_reg;
    else if (idx >= `PWMSD_IDX_CNT0 && idx < `PWMSD_IDX_PER0)
      rd_byte = ch_cnt[8*(idx - `PWMSD_IDX_CNT0) +: 8];
    else if (idx >= `PWMSD_IDX_PER0 && idx < `PWMSD_IDX_DTY0)
      rd_byte = ch_per[8*(idx - `PWMSD_IDX_PER0) +: 8];
    else if (idx >= `PWMSD_IDX_DTY0 && idx < `PWMSD_IDX_SDN)
      rd_byte = ch_dty[8*(idx - `PWMSD_IDX_DTY0) +: 8];
    else if (idx == `PWMSD_IDX_SDN)
    begin
      rd_byte[`PWMSD_SDN_FLAG] = shutdown_change_flag_reg;
      rd_byte[`PWMSD_SDN_IE] = shutdown_irq_enable_reg;
      rd_byte[`PWMSD_SDN_RESTART] = 1'b0;
      rd_byte[`PWMSD_SDN_LVL] = shutdown_output_level_reg;
      rd_byte[`PWMSD_SDN_PIN] = pin_s2_reg;
      rd_byte[`PWMSD_SDN_POL] = shutdown_active_polarity_reg;
      rd_byte[`PWMSD_SDN_ENA] = shutdown_feature_enable_reg;
    end
    else
      rd_hit = 1'b0;
  end

  // Hold and output forcing
  always @*
  begin
    hold_next = hold_reg;
    out_next = ch_wave;
    for (k = 0; k < NCH; k = k + 1)
    begin
      if (sd_active)
        hold_next[k] = 1'b1;
      else if ((restart_pend_reg | ~shutdown_feature_enable_reg) & ch_zero[k])
        hold_next[k] = 1'b0;
      if ((sd_active | hold_reg[k]) & channel_run_enable_reg[k])
        out_next[k] = shutdown_output_level_reg;
      else if (!channel_run_enable_reg[k])
        out_next[k] = 1'b0;
    end
  end

  // Bus slave and register writes
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      ack_reg <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      channel_run_enable_reg <= `PWMSD_RST_BYTE;
      pol_reg <= `PWMSD_RST_BYTE;
      clock_choice_reg <= `PWMSD_RST_BYTE;
      prescale_select_reg <= `PWMSD_RST_BYTE;
      module_control_reg <= `PWMSD_RST_BYTE;
      scale_value_a_reg <= `PWMSD_RST_BYTE;
      scale_value_b_reg <= `PWMSD_RST_BYTE;
      shutdown_irq_enable_reg <= 1'b0;
      shutdown_output_level_reg <= 1'b0;
      shutdown_active_polarity_reg <= 1'b0;
      shutdown_feature_enable_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      // Read data is taken in the setup cycle and stands through the access cycle
      if (psel && !ack_reg)
      begin
        ack_reg <= 1'b1;
        prdata <= {24'h000000, rd_byte};
        pslverr <= ~rd_hit;
      end
      else if (psel && penable && ack_reg)
      begin
        ack_reg <= 1'b0;
        pslverr <= 1'b0;
      end
      if (wr_en)
      begin
        if (idx == `PWMSD_IDX_ENABLE)
          channel_run_enable_reg <= wb;
        else if (idx == `PWMSD_IDX_POL)
          pol_reg <= wb;
        else if (idx == `PWMSD_IDX_CLKSEL)
          clock_choice_reg <= wb;
        else if (idx == `PWMSD_IDX_PRESCALE)
          prescale_select_reg <= wb & 8'h77;
        else if (idx == `PWMSD_IDX_CTRL)
          module_control_reg <= wb & 8'h04;
        else if (idx == `PWMSD_IDX_SCALE_A)
          scale_value_a_reg <= wb;
        else if (idx == `PWMSD_IDX_SCALE_B)
          scale_value_b_reg <= wb;
        else if (idx == `PWMSD_IDX_SDN)
        begin
          shutdown_irq_enable_reg <= wb[`PWMSD_SDN_IE];
          shutdown_output_level_reg <= wb[`PWMSD_SDN_LVL];
          shutdown_active_polarity_reg <= wb[`PWMSD_SDN_POL];
          shutdown_feature_enable_reg <= wb[`PWMSD_SDN_ENA];
        end
      end
    end
  end

  // Prescaler and scale counters
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      pre_cnt_reg <= 7'h00;
      sa_cnt_reg <= 8'h00;
      sb_cnt_reg <= 8'h00;
      sa_tgl_reg <= 1'b0;
      sb_tgl_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (pre_run)
        pre_cnt_reg <= pre_cnt_reg + 7'h01;
      // A scale write reloads at once so a new rate starts without a stale count
      if (scale_a_wr)
        sa_cnt_reg <= wb;
      else if (pulse_a)
        sa_cnt_reg <= scale_value_a_reg;
      else if (tick_a)
        sa_cnt_reg <= sa_cnt_reg - 8'h01;
      if (pulse_a)
        sa_tgl_reg <= ~sa_tgl_reg;
      if (scale_b_wr)
        sb_cnt_reg <= wb;
      else if (pulse_b)
        sb_cnt_reg <= scale_value_b_reg;
      else if (tick_b)
        sb_cnt_reg <= sb_cnt_reg - 8'h01;
      if (pulse_b)
        sb_tgl_reg <= ~sb_tgl_reg;
    end
  end

  // Shutdown input, flag, restart and outputs
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
      pin_s3_reg <= 1'b0;
      shutdown_change_flag_reg <= 1'b0;
      restart_pend_reg <= 1'b0;
      hold_reg <= 8'h00;
      pwm_out <= 8'h00;
      pwm_oe <= 8'h00;
      shutdown_irq <= 1'b0;
    end
    else if (clk_en)
    begin
      pin_s1_reg <= ch7_pin_in;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      // A change in the clearing cycle keeps the flag set
      if (pin_change)
        shutdown_change_flag_reg <= 1'b1;
      else if (sdn_wr && wb[`PWMSD_SDN_FLAG])
        shutdown_change_flag_reg <= 1'b0;
      // Restart is dropped while the input is active or once every channel is released
      if (sd_active || hold_next == 8'h00)
        restart_pend_reg <= 1'b0;
      else if (sdn_wr && wb[`PWMSD_SDN_RESTART])
        restart_pend_reg <= 1'b1;
      hold_reg <= hold_next;
      pwm_out <= out_next;
      // Channel 7 pin becomes an input while the shutdown feature is on
      pwm_oe <= {channel_run_enable_reg[7] & ~shutdown_feature_enable_reg,
                 channel_run_enable_reg[6:0]};
      shutdown_irq <= (shutdown_change_flag_reg | pin_change)
                      & shutdown_irq_enable_reg & shutdown_feature_enable_reg;
    end
  end
endmodule

// [hw/pwmsd_regs.vh]
// Register map, field positions and reset values of the PWM clocking and shutdown block
// Notes on behaviour
// - Flag sets on each shutdown input change; writing one clears it.
// - Interrupt request is flag and enable together; disabled means no request.
// - Restart only while input passive; channels resume after counter reaches zero.
// - Restart bit is a write-only trigger that reads as zero.
// - Clearing shutdown enable releases channels only once counters pass zero.
// - Active shutdown input forces enabled outputs at once to the programmed level.
// - Pin status bit reads the present state of the channel 7 pin.
// - Polarity bit picks low or high as the active shutdown level.
// - Shutdown enable makes channel 7 an input; otherwise other bits do nothing.
// - Clocks A and B divide the bus clock by 1 to 128 by powers of two.
// - Freeze-stop bit with freeze mode active stops the prescaler.
// - Prescaler stops when all eight channel enables are zero.
// - Scaled clocks use a reloading 8-bit down counter and a toggle stage.
// - Scale value zero counts as 256, dividing by 512.
// - Writing a scale register reloads its down counter at once.
// - Channels 0,1,4,5 pick A or SA; channels 2,3,6,7 pick B or SB.
// - Each channel has an 8-bit counter, period and duty compare.
// - Each channel selects whether its cycle starts high or low.
// - Buffered period and duty load at period end, counter write or disable.
`ifndef PWMSD_REGS_VH
`define PWMSD_REGS_VH
`define PWMSD_IDX_ENABLE 6'h00
`define PWMSD_IDX_POL 6'h01
`define PWMSD_IDX_CLKSEL 6'h02
`define PWMSD_IDX_PRESCALE 6'h03
`define PWMSD_IDX_CTRL 6'h05
`define PWMSD_IDX_SCALE_A 6'h08
`define PWMSD_IDX_SCALE_B 6'h09
`define PWMSD_IDX_CNT0 6'h0C
`define PWMSD_IDX_PER0 6'h14
`define PWMSD_IDX_DTY0 6'h1C
`define PWMSD_IDX_SDN 6'h24
`define PWMSD_PRE_A_LSB 0
`define PWMSD_PRE_B_LSB 4
`define PWMSD_CTRL_FRZ 2
`define PWMSD_SDN_FLAG 7
`define PWMSD_SDN_IE 6
`define PWMSD_SDN_RESTART 5
`define PWMSD_SDN_LVL 4
`define PWMSD_SDN_PIN 2
`define PWMSD_SDN_POL 1
`define PWMSD_SDN_ENA 0
`define PWMSD_RST_BYTE 8'h00
`define PWMSD_RST_PER 8'h00
`define PWMSD_RST_DTY 8'hFF
`endif

// [hw/pwmsd_chan.v]
// One PWM channel: 8-bit counter with double-buffered period and duty
`timescale 1ns/1ps
`include "pwmsd_regs.vh"
module pwmsd_chan (
  input wire clock,
  input wire rst_n,
  input wire clk_en,
  input wire tick,
  input wire run,
  input wire pol,
  input wire per_wr,
  input wire dty_wr,
  input wire cnt_wr,
  input wire [7:0] wdata,
  output reg [7:0] per_buf_reg,
  output reg [7:0] dty_buf_reg,
  output reg [7:0] cnt_reg,
  output wire wave,
  output wire cnt_zero
);
  reg [7:0] per_act_reg;
  reg [7:0] dty_act_reg;
  wire [8:0] cnt_inc;
  wire wrap;
  assign cnt_inc = {1'b0, cnt_reg} + 9'h001;
  assign wrap = cnt_inc >= {1'b0, per_act_reg};
  assign cnt_zero = cnt_reg == 8'h00;
  // Output starts each cycle at the polarity level and flips at the duty match
  assign wave = (cnt_reg < dty_act_reg) ? pol : ~pol;
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      per_buf_reg <= `PWMSD_RST_PER;
      dty_buf_reg <= `PWMSD_RST_DTY;
      per_act_reg <= `PWMSD_RST_PER;
      dty_act_reg <= `PWMSD_RST_DTY;
      cnt_reg <= 8'h00;
    end
    else if (clk_en)
    begin
      if (per_wr)
        per_buf_reg <= wdata;
      if (dty_wr)
        dty_buf_reg <= wdata;
      if (cnt_wr)
      begin
        cnt_reg <= 8'h00;
        per_act_reg <= per_buf_reg;
        dty_act_reg <= dty_buf_reg;
      end
      else if (!run)
      begin
        per_act_reg <= per_wr ? wdata : per_buf_reg;
        dty_act_reg <= dty_wr ? wdata : dty_buf_reg;
      end
      else if (tick)
      begin
        if (wrap)
        begin
          cnt_reg <= 8'h00;
          per_act_reg <= per_buf_reg;
          dty_act_reg <= dty_buf_reg;
        end
        else
          cnt_reg <= cnt_inc[7:0];
      end
    end
  end
endmodule

// [dv/pwmsd_chk_sva.sv]
// Port assertions for the PWM clocking and shutdown block
`timescale 1ns/1ps
`include "pwmsd_regs.vh"
module pwmsd_chk (
  input wire clock,
  input wire rst_n,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire ch7_pin_in,
  input wire [7:0] pwm_out,
  input wire [7:0] pwm_oe,
  input wire shutdown_irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  reg ena_s, pol_s, lvl_s, ie_s;
  wire done = psel && penable && pready;
  wire sdn_hit = paddr == {`PWMSD_IDX_SDN, 2'b00};
  wire clr_hit = done && pwrite && sdn_hit && pwdata[7];
  wire act = ch7_pin_in == pol_s;
  function automatic logic mapped(input logic [5:0] i);
    mapped = i <= 6'h24 && !(i == 6'h04 || i == 6'h06 || i == 6'h07 || i == 6'h0A || i == 6'h0B);
  endfunction
  // Shadow of the shutdown control bits, taken at write completion
  always @(posedge clock)
  begin
    if (!rst_n)
      {ie_s, lvl_s, pol_s, ena_s} <= 4'h0;
    else if (done && pwrite && sdn_hit)
      {ie_s, lvl_s, pol_s, ena_s} <= {pwdata[6], pwdata[4], pwdata[1:0]};
  end
  apb_answer_a: assert property (psel && !penable && !pready && clk_en |=> pready)
    else $error("pready missing after setup");
  slv_error_a: assert property (done |-> pslverr == !mapped(paddr[7:2]))
    else $error("pslverr does not match address map");
  sdn_force_a: assert property ((ena_s && act)[*3] |=>
    ((pwm_out[6:0] ^ {7{$past(lvl_s)}}) & pwm_oe[6:0]) == 7'h00)
    else $error("enabled outputs not forced to shutdown level");
  pin_input_a: assert property (ena_s && $past(ena_s) |-> !pwm_oe[7])
    else $error("channel 7 driven while shutdown enabled");
  irq_off_a: assert property (!ie_s && !$past(ie_s) |-> !shutdown_irq)
    else $error("interrupt raised while disabled");
  restart_read_a: assert property (done && !pwrite && sdn_hit |-> !prdata[5])
    else $error("restart bit reads as one");
  pin_status_a: assert property (done && !pwrite && sdn_hit && $stable(ch7_pin_in)
    && $past(ch7_pin_in) == $past(ch7_pin_in, 2)
    && $past(ch7_pin_in, 2) == $past(ch7_pin_in, 3) |-> prdata[2] == ch7_pin_in)
    else $error("pin status bit differs from pin");
  irq_cause_a: assert property ($rose(shutdown_irq) |-> $past(ch7_pin_in, 3) != $past(ch7_pin_in, 4)
    || $past(ch7_pin_in, 2) != $past(ch7_pin_in, 3) || !$past(ie_s, 2))
    else $error("interrupt rose without pin change");
  irq_hold_a: assert property ($fell(shutdown_irq) |-> !$past(ie_s) || !$past(ena_s) || $past(clr_hit)
    || $past(clr_hit, 2))
    else $error("flag dropped without clearing write");
endmodule
bind pwmsd_top pwmsd_chk pwmsd_chk_i (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .ch7_pin_in(ch7_pin_in), .pwm_out(pwm_out), .pwm_oe(pwm_oe), .shutdown_irq(shutdown_irq));

// [dv/pwmsd_tb.sv]
// Self-checking bench for the PWM clocking and shutdown block
`timescale 1ns/1ps
`include "pwmsd_regs.vh"
module testbench;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic freeze_mode = 1'b0;
  logic ch7_pin_in = 1'b0;
  logic clk_en = 1'b1;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire [7:0] pwm_out;
  wire [7:0] pwm_oe;
  wire shutdown_irq;
  int bad_count = 0;
  int checks_done = 0;
  logic [31:0] rdv;
  logic err;
  logic [7:0] sv[3] = '{8'h01, 8'h03, 8'h00};
  int sc[3] = '{1, 3, 256};
  always #5 clock = ~clock;
  pwmsd_top pwmsd_top_i (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .freeze_mode(freeze_mode), .ch7_pin_in(ch7_pin_in), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
    .shutdown_irq(shutdown_irq));
  task automatic report_and_stop();
    if (bad_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One transfer; entered just after a rising edge, leaves one idle cycle
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd);
  endtask
  task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rdv, {24'h000000, exp});
    chk(32'(err), 32'h0);
  endtask
  task automatic wait_lvl(input int ch, input logic v, inout int n);
    int k;
    k = 0;
    while (pwm_out[ch] !== v && k < 9000)
    begin
      k++;
      @(posedge clock);
    end
    n += k;
  endtask
  // Skips the first cycles after a change, then times one full period
  task automatic measure(input int ch, input int exp_per, input int exp_hi);
    int h, l;
    h = 0;
    l = 0;
    repeat (2)
    begin
      wait_lvl(ch, 1'b0, l);
      wait_lvl(ch, 1'b1, l);
    end
    l = 0;
    wait_lvl(ch, 1'b0, h);
    wait_lvl(ch, 1'b1, l);
    chk(h + l, exp_per);
    chk(h, exp_hi);
  endtask
  task automatic hold(input int ch, input logic v);
    int bad;
    bad = 0;
    repeat (40)
    begin
      @(posedge clock);
      bad += (pwm_out[ch] !== v);
    end
    chk(bad, 0);
  endtask
  initial
  begin
    repeat (90000) @(posedge clock);
    bad_count++;
    report_and_stop();
  end
  initial
  begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd(`PWMSD_IDX_ENABLE, `PWMSD_RST_BYTE);
    rd(`PWMSD_IDX_PER0, `PWMSD_RST_PER);
    rd(`PWMSD_IDX_DTY0, `PWMSD_RST_DTY);
    rd(`PWMSD_IDX_SDN, 8'h00);
    apb(1'b0, 6'h04, 8'h00);
    chk({err, rdv[30:0]}, 32'h80000000);
    apb(1'b1, 6'h0B, 8'h55);
    chk(32'(err), 32'h1);
    wr(`PWMSD_IDX_PER0, 8'h04);
    wr(`PWMSD_IDX_DTY0, 8'h01);
    wr(`PWMSD_IDX_PER0 + 6'h02, 8'h04);
    wr(`PWMSD_IDX_DTY0 + 6'h02, 8'h01);
    wr(`PWMSD_IDX_POL, 8'h01);
    wr(`PWMSD_IDX_ENABLE, 8'h05);
    for (int n = 0; n < 8; n++)
    begin
      wr(`PWMSD_IDX_ENABLE, 8'h00);
      wr(`PWMSD_IDX_PRESCALE, {1'b0, 3'(7 - n), 1'b0, 3'(n)});
      wr(`PWMSD_IDX_ENABLE, 8'h05);
      measure(0, 4 << n, 1 << n);
      measure(2, 4 << (7 - n), 3 << (7 - n));
    end
    wr(`PWMSD_IDX_ENABLE, 8'h00);
    wr(`PWMSD_IDX_PRESCALE, 8'h00);
    wr(`PWMSD_IDX_CLKSEL, 8'h05);
    for (int i = 0; i < 3; i++)
    begin
      wr(`PWMSD_IDX_SCALE_A, sv[i]);
      wr(`PWMSD_IDX_SCALE_B, sv[i]);
      wr(`PWMSD_IDX_ENABLE, 8'h05);
      measure(0, 8 * sc[i], 2 * sc[i]);
      measure(2, 8 * sc[i], 6 * sc[i]);
      wr(`PWMSD_IDX_ENABLE, 8'h00);
    end
    wr(`PWMSD_IDX_CLKSEL, 8'h00);
    wr(`PWMSD_IDX_ENABLE, 8'h05);
    wr(`PWMSD_IDX_CTRL, 8'h04);
    freeze_mode <= 1'b1;
    repeat (4) @(posedge clock);
    hold(0, pwm_out[0]);
    freeze_mode <= 1'b0;
    measure(0, 4, 1);
    // Clock enable low freezes the running channel
    clk_en <= 1'b0;
    @(posedge clock);
    hold(0, pwm_out[0]);
    clk_en <= 1'b1;
    wr(`PWMSD_IDX_DTY0, 8'h02);
    rd(`PWMSD_IDX_DTY0, 8'h02);
    measure(0, 4, 2);
    wr(`PWMSD_IDX_DTY0, 8'h01);
    wr(`PWMSD_IDX_CNT0, 8'h00);
    measure(0, 4, 1);
    wr(`PWMSD_IDX_ENABLE, 8'h85);
    wr(`PWMSD_IDX_SDN, 8'h53);
    ch7_pin_in <= 1'b1;
    repeat (5) @(posedge clock);
    chk(32'(pwm_oe), 32'h05);
    chk(32'(shutdown_irq), 32'h1);
    hold(0, 1'b1);
    rd(`PWMSD_IDX_SDN, 8'hD7);
    wr(`PWMSD_IDX_SDN, 8'hF3);
    hold(0, 1'b1);
    chk(32'(shutdown_irq), 32'h0);
    rd(`PWMSD_IDX_SDN, 8'h57);
    ch7_pin_in <= 1'b0;
    repeat (5) @(posedge clock);
    rd(`PWMSD_IDX_SDN, 8'hD3);
    hold(0, 1'b1);
    wr(`PWMSD_IDX_SDN, 8'hF3);
    measure(0, 4, 1);
    wr(`PWMSD_IDX_SDN, 8'h80);
    ch7_pin_in <= 1'b1;
    repeat (5) @(posedge clock);
    rd(`PWMSD_IDX_SDN, 8'h04);
    chk(32'(pwm_oe), 32'h85);
    wr(`PWMSD_IDX_SDN, 8'h01);
    ch7_pin_in <= 1'b0;
    repeat (5) @(posedge clock);
    hold(0, 1'b0);
    chk(32'(shutdown_irq), 32'h0);
    rd(`PWMSD_IDX_SDN, 8'h81);
    wr(`PWMSD_IDX_SDN, 8'h80);
    measure(0, 4, 1);
    report_and_stop();
  end
endmodule
